// [hdl/scs_top.sv]
// Function
// - sensed current above threshold fires the one-shot off-time pulse
// - during off-time the sink opens, winding recirculates, then re-energizes
// - off-time lasts about 1.1 times R times C
// - threshold equals reference times code over 16
// - overcurrent above 12A turns off both upper switches
// - restart by itself about 3 us after fault current reaches zero
// - over-temperature disables bridge, restarts below threshold minus hysteresis
// - supply below lockout disables bridge, restarts when it recovers
// - four threshold inputs form one unsigned code, first is msb
// - brake high turns on both upper switches
// - direction picks upper switch, opposite sink on while pulse low
module scs_top (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic [3:0]  threshold_code_a_i,
   input  wire logic [3:0]  threshold_code_b_i,
   input  wire logic [1:0]  dir_i,
   input  wire logic [1:0]  brake_i,
   input  wire logic [7:0]  sense_a_i,
   input  wire logic [7:0]  sense_b_i,
   input  wire logic [1:0]  oc_det_i,
   input  wire logic [1:0]  cur_zero_i,
   input  wire logic        temp_over_i,
   input  wire logic        temp_clear_i,
   input  wire logic        supply_low_i,
   output logic      [1:0]  src1_o,
   output logic      [1:0]  src2_o,
   output logic      [1:0]  snk1_o,
   output logic      [1:0]  snk2_o,
   output logic      [1:0]  off_time_pulse_o,
   output logic      [1:0]  oc_lock_o
);
   logic [7:0]  ref_q;
   logic [15:0] rc_q;
   logic [19:0] rc_prod;
   logic [15:0] off_cyc_d;
   logic [15:0] off_cyc_q;
   logic        therm_q;
   logic        enable;
   logic [31:0] rdata_q;
   logic [31:0] rd_d;
   logic [3:0]  code_arr [2];
   logic [7:0]  sense_arr [2];

   assign code_arr[0]  = threshold_code_a_i;
   assign code_arr[1]  = threshold_code_b_i;
   assign sense_arr[0] = sense_a_i;
   assign sense_arr[1] = sense_b_i;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ref_q <= scs_pkg::REF_RST;
         rc_q  <= scs_pkg::RC_RST;
      end else if (wr_i) begin
         if (addr_i == scs_pkg::ADDR_REF) begin
            ref_q <= wdata_i[7:0];
         end
         if (addr_i == scs_pkg::ADDR_RC) begin
            rc_q <= wdata_i[15:0];
         end
      end
   end

   // rc in ns; divide folded into a registered stage to keep the divider off the pulse path
   assign rc_prod = 20'(rc_q * scs_pkg::OFF_MUL);
   always_comb begin
      off_cyc_d = 16'(rc_prod / 20'(scs_pkg::OFF_SCALE));
      if (off_cyc_d == 16'h0000) begin
         off_cyc_d = 16'h0001;
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         off_cyc_q <= 16'h0001;
      end else begin
         off_cyc_q <= off_cyc_d;
      end
   end

   // hysteresis comes from the two sensor comparators
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         therm_q <= 1'b0;
      end else if (temp_over_i) begin
         therm_q <= 1'b1;
      end else if (temp_clear_i) begin
         therm_q <= 1'b0;
      end
   end

   assign enable = !therm_q && !supply_low_i;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_wind
         scs_wind_if wi ();
         assign wi.code        = code_arr[g];
         assign wi.dir         = dir_i[g];
         assign wi.brake       = brake_i[g];
         assign wi.sense       = sense_arr[g];
         assign wi.oc_det      = oc_det_i[g];
         assign wi.cur_zero    = cur_zero_i[g];
         assign src1_o[g]           = wi.src1;
         assign src2_o[g]           = wi.src2;
         assign snk1_o[g]           = wi.snk1;
         assign snk2_o[g]           = wi.snk2;
         assign off_time_pulse_o[g] = wi.pulse;
         assign oc_lock_o[g]        = wi.oc_lock;
         scs_bridge u_bridge (
            .mclk_i    (mclk_i),
            .sys_rst_i (sys_rst_i),
            .enable_i  (enable),
            .off_cyc_i (off_cyc_q),
            .ref_i     (ref_q),
            .w         (wi.dev)
         );
      end
   endgenerate

   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (addr_i)
         scs_pkg::ADDR_REF:    rd_d[7:0]  = ref_q;
         scs_pkg::ADDR_RC:     rd_d[15:0] = rc_q;
         scs_pkg::ADDR_STATUS: begin
            rd_d[scs_pkg::ST_PULSE_LSB +: 2] = off_time_pulse_o;
            rd_d[scs_pkg::ST_OCLK_LSB +: 2]  = oc_lock_o;
            rd_d[scs_pkg::ST_THERM]          = therm_q;
            rd_d[scs_pkg::ST_UVLO]           = supply_low_i;
         end
         default:              rd_d = 32'h0000_0000;
      endcase
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rd_i ? rd_d : 32'h0000_0000;
      end
   end

   assign rdata_o = rdata_q;

   a_therm_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      temp_over_i |-> ##2 (src1_o == 2'b00 && src2_o == 2'b00 && snk1_o == 2'b00 && snk2_o == 2'b00))
      else $error("bridge on during over-temperature");
   a_therm_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (therm_q && !temp_clear_i) |=> therm_q) else $error("thermal lock released early");
   a_uvlo_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      supply_low_i |=> (src1_o == 2'b00 && src2_o == 2'b00 && snk1_o == 2'b00 && snk2_o == 2'b00))
      else $error("bridge on during undervoltage");
   a_uvlo_restart: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      ($fell(supply_low_i) && !therm_q && !oc_lock_o[0] && !brake_i[0] && dir_i[0])
      |=> (src2_o[0] && !src1_o[0]))
      else $error("no restart after undervoltage");
   a_read_once: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !$past(rd_i) |-> (rdata_o == 32'h0000_0000)) else $error("read data outside its cycle");
endmodule // scs_top

// [include/scs_pkg.sv]
package scs_pkg;
   // register map, byte addresses on the plain register port
   localparam logic [7:0]  ADDR_REF      = 8'h00;
   localparam logic [7:0]  ADDR_RC       = 8'h04;
   localparam logic [7:0]  ADDR_STATUS   = 8'h08;
   localparam logic [7:0]  REF_RST       = 8'h80;
   // 20 kohm * 2.2 nF = 44000 ns
   localparam logic [15:0] RC_RST        = 16'hABE0;

   // status field positions
   localparam int unsigned ST_PULSE_LSB  = 0;
   localparam int unsigned ST_OCLK_LSB   = 2;
   localparam int unsigned ST_THERM      = 4;
   localparam int unsigned ST_UVLO       = 5;

   localparam int unsigned NUM_WIND      = 2;
   localparam int unsigned CODE_W        = 4;
   localparam int unsigned LEVEL_W       = 8;
   localparam int unsigned CNT_W         = 16;
   // threshold = ref * code / 16
   localparam int unsigned CODE_SHIFT    = 4;

   localparam int unsigned CLK_PERIOD_NS = 40;
   // off-time = 1.1 * RC
   localparam int unsigned OFF_MUL       = 11;
   localparam int unsigned OFF_DIV       = 10;
   localparam int unsigned RESTART_NS    = 3000;
   localparam int unsigned RESTART_CYC   = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OFF_SCALE     = OFF_DIV * CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      OC_RUN,
      OC_DECAY,
      OC_WAIT
   } scs_oc_t;
endpackage

// [include/scs_wind_if.sv]
interface scs_wind_if;
   logic [3:0] code;
   logic       dir;
   logic       brake;
   logic [7:0] sense;
   logic       oc_det;
   logic       cur_zero;
   logic       src1;
   logic       src2;
   logic       snk1;
   logic       snk2;
   logic       pulse;
   logic       oc_lock;

   modport dev (
      input  code, dir, brake, sense, oc_det, cur_zero,
      output src1, src2, snk1, snk2, pulse, oc_lock
   );
   modport ctl (
      output code, dir, brake, sense, oc_det, cur_zero,
      input  src1, src2, snk1, snk2, pulse, oc_lock
   );
endinterface

// [hdl/scs_bridge.sv]
module scs_bridge (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        enable_i,
   input  wire logic [15:0] off_cyc_i,
   input  wire logic [7:0]  ref_i,
   scs_wind_if.dev          w
);
   logic [11:0]           thr_prod;
   logic [7:0]            thr;
   logic                  trip;
   logic [15:0]           cnt_q;
   logic                  pulse_q;
   scs_pkg::scs_oc_t      st_q;
   logic [6:0]            rcnt_q;
   logic                  run;
   logic                  src1_q, src2_q, snk1_q, snk2_q;

   // code bit 3 is the msb, straight unsigned binary
   assign thr_prod = 12'(ref_i) * 12'(w.code);
   assign thr      = thr_prod[11:scs_pkg::CODE_SHIFT];
   assign trip     = w.sense > thr;

   // one-shot; retriggers only after the pulse has ended
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q   <= 16'h0000;
         pulse_q <= 1'b0;
      end else if (!pulse_q) begin
         if (trip) begin
            pulse_q <= 1'b1;
            cnt_q   <= off_cyc_i - 16'h0001;
         end
      end else if (cnt_q == 16'h0000) begin
         pulse_q <= 1'b0;
      end else begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   // overcurrent: upper switches off, restart after current reaches zero
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q   <= scs_pkg::OC_RUN;
         rcnt_q <= 7'h00;
      end else begin
         unique case (st_q)
            scs_pkg::OC_RUN: begin
               if (w.oc_det) begin
                  st_q <= scs_pkg::OC_DECAY;
               end
            end
            scs_pkg::OC_DECAY: begin
               if (w.cur_zero) begin
                  st_q   <= scs_pkg::OC_WAIT;
                  rcnt_q <= 7'(scs_pkg::RESTART_CYC - 1);
               end
            end
            scs_pkg::OC_WAIT: begin
               if (rcnt_q == 7'h00) begin
                  st_q <= w.oc_det ? scs_pkg::OC_DECAY : scs_pkg::OC_RUN;
               end else begin
                  rcnt_q <= rcnt_q - 7'h01;
               end
            end
            default: begin
               st_q <= scs_pkg::OC_RUN;
            end
         endcase
      end
   end

   assign run = (st_q == scs_pkg::OC_RUN);

   // sink drops while the off-time pulse is high so the winding recirculates
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         src1_q <= 1'b0;
         src2_q <= 1'b0;
         snk1_q <= 1'b0;
         snk2_q <= 1'b0;
      end else begin
         src1_q <= enable_i && run && (w.brake || !w.dir);
         src2_q <= enable_i && run && (w.brake || w.dir);
         snk1_q <= enable_i && !w.brake && w.dir && !pulse_q;
         snk2_q <= enable_i && !w.brake && !w.dir && !pulse_q;
      end
   end

   assign w.src1    = src1_q;
   assign w.src2    = src2_q;
   assign w.snk1    = snk1_q;
   assign w.snk2    = snk2_q;
   assign w.pulse   = pulse_q;
   assign w.oc_lock = !run;

   // helpers for assertions
   logic [15:0] pw_q;
   logic [15:0] off_lat_q;
   logic [6:0]  wt_q;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pw_q      <= 16'h0000;
         off_lat_q <= 16'h0000;
         wt_q      <= 7'h00;
      end else begin
         pw_q <= pulse_q ? pw_q + 16'h0001 : 16'h0000;
         if (!pulse_q && trip) begin
            off_lat_q <= off_cyc_i;
         end
         wt_q <= (st_q == scs_pkg::OC_WAIT) ? wt_q + 7'h01 : 7'h00;
      end
   end

   a_pulse_fires: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (!pulse_q && trip) |=> pulse_q) else $error("one-shot did not fire on trip");
   // width counter already holds the full length when the pulse is first seen low
   a_pulse_width: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      $fell(pulse_q) |-> (pw_q == off_lat_q)) else $error("off-time width wrong");
   a_sink_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      pulse_q |=> (!snk1_q && !snk2_q)) else $error("sink on during off-time");
   a_sink_back: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      ($fell(pulse_q) && enable_i && !w.brake && w.dir) |=> snk1_q) else $error("sink not restored");
   a_brake_both: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (w.brake && enable_i && run) |=> (src1_q && src2_q && !snk1_q && !snk2_q))
      else $error("brake did not short load");
   a_dir_high: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (!w.brake && w.dir && enable_i && run && !pulse_q) |=> (src2_q && snk1_q && !src1_q && !snk2_q))
      else $error("direction high drive wrong");
   a_oc_upper: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (run && w.oc_det) |-> ##2 (!src1_q && !src2_q)) else $error("uppers on after overcurrent");
   a_restart_wait: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      ($past(st_q) == scs_pkg::OC_WAIT && st_q != scs_pkg::OC_WAIT)
      |-> ($past(wt_q) == 7'(scs_pkg::RESTART_CYC - 1)))
      else $error("restart delay wrong");
   a_code_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (w.code == 4'h0 && w.sense == 8'h00 && !pulse_q) |=> !pulse_q) else $error("zero code tripped");
endmodule // scs_bridge

// [testbench/scs_ctl_model.sv]
module scs_ctl_model (
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       step_i,
   input  wire logic       rev_i,
   input  wire logic [1:0] mode_i,
   output logic      [3:0] code_a_o,
   output logic      [3:0] code_b_o,
   output logic      [1:0] dir_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // rows {code a, code b, dir b, dir a}; idle winding keeps a fixed direction only in mode 0
   localparam logic [9:0] TBL [0:31] = '{
      10'h3C3, 10'h03F, 10'h3C2, 10'h03D, 10'h3C3, 10'h03F, 10'h3C2, 10'h03D,
      10'h3FF, 10'h3FE, 10'h3FC, 10'h3FD, 10'h3FF, 10'h3FE, 10'h3FC, 10'h3FD,
      10'h3C3, 10'h3FF, 10'h03F, 10'h3FE, 10'h3C2, 10'h3FC, 10'h03C, 10'h3FD,
      10'h3C3, 10'h2EF, 10'h03E, 10'h2EE, 10'h3C0, 10'h2EC, 10'h03D, 10'h2ED};
   logic [2:0] idx_q;
   logic [9:0] row;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idx_q <= 3'h0;
      end else if (step_i) begin
         idx_q <= rev_i ? idx_q - 3'h1 : idx_q + 3'h1;
      end
   end

   // registered index keeps code and direction together between steps
   assign row      = TBL[{mode_i, idx_q}];
   assign code_a_o = row[9:6];
   assign code_b_o = row[5:2];
   assign dir_o    = row[1:0];
endmodule // scs_ctl_model

// [testbench/scs_top_tb.sv]
module scs_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RC_T  = 400;
   localparam int N_OFF = RC_T * 11 / 10 / 40;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [3:0]  code_a = 4'h0, code_b = 4'h0, mdl_a, mdl_b;
   logic [1:0]  dir_r = 2'h0, brake_i = 2'h0, oc_det_i = 2'h0, cur_zero_i = 2'h0, mode = 2'h0, mdl_dir;
   logic [1:0]  src1_o, src2_o, snk1_o, snk2_o, pulse_o, oc_lock_o;
   logic [7:0]  sense_a = 8'h00, sense_b = 8'h00;
   logic        temp_over_i = 1'b0, temp_clear_i = 1'b0, supply_low_i = 1'b0;
   logic        use_mdl = 1'b0, step = 1'b0, rev = 1'b0;
   logic [7:0]  dir_a_exp [4] = '{8'hBB, 8'h99, 8'h87, 8'hC3};
   logic [7:0]  dir_b_exp [4] = '{8'h77, 8'h33, 8'h1F, 8'h0F};
   // {code a, code b} per microstep angle, 0 to 315 degrees
   logic [7:0]  mag_exp [8] = '{8'hF0, 8'hBB, 8'h0F, 8'hBB, 8'hF0, 8'hBB, 8'h0F, 8'hBB};
   int          bad_count = 0;
   int          check_count = 0;
   int          n;

   initial forever #20 mclk_i = ~mclk_i;

   scs_ctl_model mdl (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .step_i(step), .rev_i(rev), .mode_i(mode),
      .code_a_o(mdl_a), .code_b_o(mdl_b), .dir_o(mdl_dir));

   scs_top uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .threshold_code_a_i(use_mdl ? mdl_a : code_a),
      .threshold_code_b_i(use_mdl ? mdl_b : code_b), .dir_i(use_mdl ? mdl_dir : dir_r), .brake_i(brake_i),
      .sense_a_i(sense_a), .sense_b_i(sense_b), .oc_det_i(oc_det_i), .cur_zero_i(cur_zero_i),
      .temp_over_i(temp_over_i), .temp_clear_i(temp_clear_i), .supply_low_i(supply_low_i),
      .src1_o(src1_o), .src2_o(src2_o), .snk1_o(snk1_o), .snk2_o(snk2_o), .off_time_pulse_o(pulse_o),
      .oc_lock_o(oc_lock_o));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask

   // sense is dropped once the pulse is seen so no retrigger lengthens it
   task automatic pulse_len(output int len);
      int t;
      t = 0;
      len = 0;
      while (pulse_o[0] !== 1'b1 && t < 50) begin
         @(posedge mclk_i);
         #1;
         t++;
      end
      while (pulse_o[0] === 1'b1 && len < 2000) begin
         @(posedge mclk_i);
         sense_a <= 8'h00;
         #1;
         len++;
      end
   endtask

   task automatic adv(input logic r);
      @(posedge mclk_i);
      step <= 1'b1;
      rev <= r;
      @(posedge mclk_i);
      step <= 1'b0;
      tick(2);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #(40 * 40000);
      bad_count++;
      test_done;
   end

   initial begin
      repeat (4) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      rd(scs_pkg::ADDR_REF, 32'(scs_pkg::REF_RST));
      rd(scs_pkg::ADDR_RC, 32'(scs_pkg::RC_RST));
      rd(8'h0C, 32'h0000_0000);
      wr(scs_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      rd(scs_pkg::ADDR_STATUS, 32'h0000_0000);
      wr(scs_pkg::ADDR_REF, 32'hFFFF_FF3C);
      rd(scs_pkg::ADDR_REF, 32'h0000_003C);
      wr(scs_pkg::ADDR_REF, 32'(scs_pkg::REF_RST));
      wr(scs_pkg::ADDR_RC, 32'(RC_T));
      rd(scs_pkg::ADDR_RC, 32'(RC_T));
      @(posedge mclk_i);
      dir_r <= 2'h3;
      tick(2);
      chk({src1_o, src2_o, snk1_o, snk2_o}, 8'h3C);
      dir_r <= 2'h0;
      tick(2);
      chk({src1_o, src2_o, snk1_o, snk2_o}, 8'hC3);
      brake_i <= 2'h3;
      tick(2);
      chk({src1_o, src2_o, snk1_o, snk2_o}, 8'hF0);
      brake_i <= 2'h0;
      dir_r <= 2'h3;
      code_a <= 4'h8;
      sense_a <= 8'h40;
      tick(4);
      chk(pulse_o, 2'h0);
      sense_a <= 8'h41;
      tick(3);
      chk({pulse_o[0], src2_o[0], snk1_o[0]}, 3'h6);
      sense_a <= 8'h00;
      tick(N_OFF + 2);
      chk({pulse_o[0], src2_o[0], snk1_o[0]}, 3'h3);
      sense_a <= 8'h41;
      pulse_len(n);
      chk(n, N_OFF);
      code_a <= 4'h0;
      sense_a <= 8'h01;
      tick(3);
      chk(pulse_o[0], 1'b1);
      sense_a <= 8'h00;
      tick(N_OFF + 3);
      oc_det_i <= 2'h1;
      tick(3);
      chk({oc_lock_o[0], src1_o[0], src2_o[0]}, 3'h4);
      oc_det_i <= 2'h0;
      cur_zero_i <= 2'h1;
      n = 0;
      while (oc_lock_o[0] !== 1'b0 && n < 200) begin
         tick(1);
         n++;
      end
      chk(n >= 75 && n <= 79, 1'b1);
      cur_zero_i <= 2'h0;
      tick(2);
      chk(src2_o[0], 1'b1);
      temp_over_i <= 1'b1;
      tick(3);
      chk({src2_o, snk1_o}, 4'h0);
      temp_over_i <= 1'b0;
      tick(3);
      chk({src2_o, snk1_o}, 4'h0);
      rd(scs_pkg::ADDR_STATUS, 32'h0000_0010);
      temp_clear_i <= 1'b1;
      tick(3);
      chk({src2_o, snk1_o}, 4'hF);
      temp_clear_i <= 1'b0;
      supply_low_i <= 1'b1;
      tick(2);
      chk({src2_o, snk1_o}, 4'h0);
      rd(scs_pkg::ADDR_STATUS, 32'h0000_0020);
      supply_low_i <= 1'b0;
      tick(2);
      chk({src2_o, snk1_o}, 4'hF);
      use_mdl <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         @(posedge mclk_i);
         mode <= m[1:0];
         for (int i = 1; i <= 8; i++) begin
            adv(1'b0);
            chk(src2_o, {dir_b_exp[m][i % 8], dir_a_exp[m][i % 8]});
            if (m == 3) begin
               chk({mdl_a, mdl_b}, mag_exp[i % 8]);
            end
         end
      end
      adv(1'b1);
      chk(src2_o, 2'h1);
      // mid-run reset: switches drop at once, registers return to defaults
      sys_rst_i <= 1'b1;
      tick(2);
      chk({src2_o, oc_lock_o, pulse_o}, 6'h00);
      sys_rst_i <= 1'b0;
      rd(scs_pkg::ADDR_RC, 32'(scs_pkg::RC_RST));
      test_done;
   end
endmodule // scs_top_tb
